// file: nvm_cmd_map.vh
/*
 * register offsets, field positions, reset values and command codes
 * of the non-volatile command and busy control block.
 * assumes inclusion by bare name from the design files.
 */
`ifndef NVM_CMD_MAP_VH
`define NVM_CMD_MAP_VH

`define CMD_SELECT_OFFSET   8'h33
`define BUSY_STATUS_OFFSET  8'h32
`define CMD_SELECT_RESET    8'h00
`define CMD_FIELD_RESET     6'h00
`define LOW_BYTE_RESET      8'h00
`define BUSY_STATUS_RESET   8'h00
`define CMD_FIELD_MSB       5
`define BUSY_FLAG_BIT       7

`define CMD_NO_OPERATION    6'h00
`define CMD_CHIP_ERASE      6'h10
`define CMD_SECTION_ERASE   6'h14
`define CMD_WORD_WRITE      6'h1D

`define ERASE_CYCLES        16'h0040
`define WRITE_CYCLES        16'h0010

`endif

// file: nvm_op_timer.v
/*
 * operation timer: counts a programmed length once started and flags done.
 * assumes start pulses only while idle; one clock, async low reset.
 */
module nvm_op_timer #(
  parameter CNT_W = 16
) (
  input  wire             clk_in,
  input  wire             resetn_in,
  input  wire             start_in,
  input  wire [CNT_W-1:0] length_in,
  output wire             running_out,
  output reg              done_out
);

  reg [CNT_W-1:0] count_reg;
  reg             run_reg;

  assign running_out = run_reg;

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_reg <= {CNT_W{1'b0}};
      run_reg   <= 1'b0;
      done_out  <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (start_in && !run_reg) begin
        count_reg <= length_in;
        run_reg   <= 1'b1;
      end else if (run_reg) begin
        // length of zero still takes one cycle
        if (count_reg <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
          run_reg  <= 1'b0;
          done_out <= 1'b1;
        end else begin
          count_reg <= count_reg - {{(CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

endmodule // nvm_op_timer

// file: nvm_command_busy_control.v
/*
 * command and busy control of the non-volatile memory controller:
 * command register, busy status, byte-to-word latch, access gating.
 * assumes the programmer's register and memory-mapped accesses arrive
 * as single-cycle strobes on clk_in; flash array lives outside, op timer inside.
 */
// Behaviour
// - busy flag at status bit 7, zero after reset, shows programming running.
// - busy sets when operation starts, clears only after it fully finishes.
// - six-bit command in bits 5:0 at offset 0x33, reset 0x00.
// - codes 0x00 nop, 0x10 chip erase, 0x14 section erase, 0x1D word write.
// - command register writes are ignored while busy.
// - word write: low byte buffered, high byte write latches word and starts.
// - erase starts on dummy high-byte write after erase command loaded.
// - while busy, other programming and all memory reads are blocked.
`include "nvm_cmd_map.vh"
module nvm_command_busy_control #(
  parameter ADDR_W   = 10,
  parameter CNT_W    = 16,
  parameter [15:0] ERASE_LEN = `ERASE_CYCLES,
  parameter [15:0] WRITE_LEN = `WRITE_CYCLES
) (
  input  wire              clk_in,
  input  wire              resetn_in,
  // register port
  input  wire              reg_wr_in,
  input  wire              reg_rd_in,
  input  wire [7:0]        reg_addr_in,
  input  wire [7:0]        reg_wdata_in,
  output reg  [7:0]        reg_rdata_out,
  // memory-mapped nonvolatile access
  input  wire              mem_wr_in,
  input  wire              mem_rd_in,
  input  wire [ADDR_W-1:0] mem_addr_in,
  input  wire [7:0]        mem_wdata_in,
  output wire              mem_rd_grant_out,
  // to flash array
  output reg               op_start_out,
  output reg  [5:0]        op_cmd_out,
  output reg  [ADDR_W-2:0] op_word_addr_out,
  output reg  [15:0]       op_data_out,
  output wire              program_busy_flag_out
);

  localparam ST_IDLE = 2'b01;
  localparam ST_BUSY = 2'b10;

  reg  [1:0]       state_reg;
  reg  [1:0]       state_next;
  reg  [5:0]       cmd_reg;
  reg  [5:0]       cmd_next;
  reg  [7:0]       low_byte_reg;
  reg  [7:0]       low_byte_next;
  reg  [7:0]       rdata_next;
  wire             busy;
  wire             timer_done;
  wire             timer_running;
  wire             cmd_wr_hit;
  wire             low_wr;
  wire             high_wr;
  wire             start_now;
  wire [CNT_W-1:0] op_length;

  // only these three codes start array work; nop and unknown codes do nothing
  function is_op_cmd;
    input [5:0] code;
    begin
      is_op_cmd = (code == `CMD_CHIP_ERASE) ||
                  (code == `CMD_SECTION_ERASE) ||
                  (code == `CMD_WORD_WRITE);
    end
  endfunction

  // erase runs the long count, word write the short one
  function [CNT_W-1:0] op_length_for;
    input [5:0] code;
    begin
      if (code == `CMD_WORD_WRITE) begin
        op_length_for = WRITE_LEN[CNT_W-1:0];
      end else begin
        op_length_for = ERASE_LEN[CNT_W-1:0];
      end
    end
  endfunction

  // status shows only the busy bit, all others read zero
  function [7:0] status_word;
    input busy_bit;
    begin
      status_word                 = `BUSY_STATUS_RESET;
      status_word[`BUSY_FLAG_BIT] = busy_bit;
    end
  endfunction

  // top two bits have no storage, so they always read zero
  function [7:0] cmd_word;
    input [5:0] code;
    begin
      cmd_word                   = `CMD_SELECT_RESET;
      cmd_word[`CMD_FIELD_MSB:0] = code;
    end
  endfunction

  assign busy                  = state_reg[1];
  assign program_busy_flag_out = busy;
  assign mem_rd_grant_out      = mem_rd_in && !busy;
  assign cmd_wr_hit            = reg_wr_in && (reg_addr_in == `CMD_SELECT_OFFSET) && !busy;
  assign low_wr                = mem_wr_in && !mem_addr_in[0] && !busy;
  assign high_wr               = mem_wr_in && mem_addr_in[0] && !busy;
  assign start_now             = high_wr && is_op_cmd(cmd_reg);
  assign op_length             = op_length_for(cmd_reg);

  // command register: loads only between operations
  always @* begin
    cmd_next = cmd_reg;
    if (cmd_wr_hit) begin
      cmd_next = reg_wdata_in[`CMD_FIELD_MSB:0];
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cmd_reg <= `CMD_FIELD_RESET;
    end else begin
      cmd_reg <= cmd_next;
    end
  end

  // low byte buffer, not tied to the address of the later high byte
  always @* begin
    low_byte_next = low_byte_reg;
    if (low_wr) begin
      low_byte_next = mem_wdata_in;
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      low_byte_reg <= `LOW_BYTE_RESET;
    end else begin
      low_byte_reg <= low_byte_next;
    end
  end

  // launch pulse stands for exactly one cycle
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op_start_out <= 1'b0;
    end else begin
      op_start_out <= start_now;
    end
  end

  // payload captured with the launch, stands until the next launch
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      op_cmd_out       <= `CMD_FIELD_RESET;
      op_word_addr_out <= {(ADDR_W-1){1'b0}};
      op_data_out      <= 16'h0000;
    end else if (start_now) begin
      op_cmd_out       <= cmd_reg;
      op_word_addr_out <= mem_addr_in[ADDR_W-1:1];
      op_data_out      <= {mem_wdata_in, low_byte_reg};
    end
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_now) begin
          state_next = ST_BUSY;
        end
      end
      ST_BUSY: begin
        // leave only once the timer has fully stopped
        if (timer_done && !timer_running) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  nvm_op_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .clk_in      (clk_in),
    .resetn_in   (resetn_in),
    .start_in    (start_now),
    .length_in   (op_length),
    .running_out (timer_running),
    .done_out    (timer_done)
  );

  // read data holds until the next read strobe
  always @* begin
    rdata_next = reg_rdata_out;
    if (reg_rd_in) begin
      case (reg_addr_in)
        `CMD_SELECT_OFFSET: begin
          rdata_next = cmd_word(cmd_reg);
        end
        `BUSY_STATUS_OFFSET: begin
          rdata_next = status_word(busy);
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= `BUSY_STATUS_RESET;
    end else begin
      reg_rdata_out <= rdata_next;
    end
  end

endmodule // nvm_command_busy_control

// file: nvm_cbc_asserts.sv
/* port checker of the command and busy control block.
   assumes one clock, async low reset, default parameters. */
module nvm_cbc_asserts (
  input wire logic        clk_in,
  input wire logic        resetn_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        mem_wr_in,
  input wire logic        mem_rd_in,
  input wire logic [9:0]  mem_addr_in,
  input wire logic [7:0]  mem_wdata_in,
  input wire logic        mem_rd_grant_out,
  input wire logic        op_start_out,
  input wire logic [5:0]  op_cmd_out,
  input wire logic [8:0]  op_word_addr_out,
  input wire logic [15:0] op_data_out,
  input wire logic        program_busy_flag_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_busy_blocks_read: assert property (program_busy_flag_out |-> !mem_rd_grant_out)
    else $error("read granted while busy");
  a_start_sets_busy: assert property (op_start_out |-> program_busy_flag_out ##1 program_busy_flag_out)
    else $error("busy missing after start");
  a_start_valid_cmd: assert property (op_start_out |-> op_cmd_out inside {6'h10, 6'h14, 6'h1D})
    else $error("start with bad command");
  a_busy_from_high: assert property ($rose(program_busy_flag_out) |-> $past(mem_wr_in) && $past(mem_addr_in[0]))
    else $error("busy without high byte write");
  a_busy_min_hold: assert property ($rose(program_busy_flag_out) |-> program_busy_flag_out [*4])
    else $error("busy dropped early");
  a_no_start_busy: assert property (program_busy_flag_out && !$rose(program_busy_flag_out) |-> !op_start_out)
    else $error("start while busy");
  property p_status_read;
    reg_rd_in && reg_addr_in == 8'h32 |=> reg_rdata_out == {$past(program_busy_flag_out), 7'h00};
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("bad status read");
  a_cmd_top_zero: assert property (reg_rd_in && reg_addr_in == 8'h33 |=> reg_rdata_out[7:6] == 2'b00)
    else $error("command top bits set");
  c_word: cover property (op_start_out && op_cmd_out == 6'h1D);
  c_chip: cover property (op_start_out && op_cmd_out == 6'h10);
  c_section: cover property (op_start_out && op_cmd_out == 6'h14);
endmodule // nvm_cbc_asserts
bind nvm_command_busy_control nvm_cbc_asserts i_nvm_cbc_asserts (
  .clk_in                (clk_in),
  .resetn_in             (resetn_in),
  .reg_wr_in             (reg_wr_in),
  .reg_rd_in             (reg_rd_in),
  .reg_addr_in           (reg_addr_in),
  .reg_wdata_in          (reg_wdata_in),
  .reg_rdata_out         (reg_rdata_out),
  .mem_wr_in             (mem_wr_in),
  .mem_rd_in             (mem_rd_in),
  .mem_addr_in           (mem_addr_in),
  .mem_wdata_in          (mem_wdata_in),
  .mem_rd_grant_out      (mem_rd_grant_out),
  .op_start_out          (op_start_out),
  .op_cmd_out            (op_cmd_out),
  .op_word_addr_out      (op_word_addr_out),
  .op_data_out           (op_data_out),
  .program_busy_flag_out (program_busy_flag_out)
);

// file: nvm_prog_model.sv
/* programmer model: one-cycle register and memory strobes.
   assumes the caller paces it; data lines inverted once released. */
module nvm_prog_model (
  input  wire logic       clk_in,
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  output logic            mem_wr_out,
  output logic [7:0]      reg_addr_out,
  output logic [7:0]      reg_wdata_out,
  output logic [7:0]      mem_wdata_out,
  output logic [9:0]      mem_addr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {reg_wr_out, reg_rd_out, mem_wr_out, reg_addr_out, reg_wdata_out, mem_wdata_out, mem_addr_out} = '0;
  task reg_op(input logic w, input logic [7:0] a, d); // command loaded first
    @(posedge clk_in); #1;
    {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} = {w, !w, a, d};
    @(posedge clk_in); #1;
    {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out} = {2'b00, ~a, ~d};
  endtask
  task mem_wr(input logic [9:0] a, input logic [7:0] d); // low byte before high
    @(posedge clk_in); #1;
    {mem_wr_out, mem_addr_out, mem_wdata_out} = {1'b1, a, d};
    @(posedge clk_in); #1;
    {mem_wr_out, mem_addr_out, mem_wdata_out} = {1'b0, ~a, ~d};
  endtask
endmodule // nvm_prog_model

// file: nvm_command_busy_control_tb.sv
/* self-checking bench of the command and busy control block.
   assumes short operation lengths; programmer model drives strobes. */
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module nvm_command_busy_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 0, resetn_in = 0, mem_rd_in = 0, gnt, start, busy, w, r, mw;
  logic [7:0] rdata, ra, rd, md;
  logic [5:0] cmd;
  logic [8:0] waddr;
  logic [15:0] wdata;
  logic [9:0] ma;
  localparam logic [15:0] ERASE_LEN_TB = 16'h000C;
  localparam logic [15:0] WRITE_LEN_TB = 16'h0008;
  int error_cnt = 0, checks = 0, cyc = 0;
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) cyc <= cyc + 1;
  nvm_prog_model i_nvm_prog_model (.clk_in(clk_in), .reg_wr_out(w), .reg_rd_out(r), .mem_wr_out(mw),
    .reg_addr_out(ra), .reg_wdata_out(rd), .mem_wdata_out(md), .mem_addr_out(ma));
  nvm_command_busy_control #(.ERASE_LEN(ERASE_LEN_TB), .WRITE_LEN(WRITE_LEN_TB)) i_nvm_command_busy_control (
    .clk_in(clk_in), .resetn_in(resetn_in), .reg_wr_in(w), .reg_rd_in(r), .reg_addr_in(ra),
    .reg_wdata_in(rd), .reg_rdata_out(rdata), .mem_wr_in(mw), .mem_rd_in(mem_rd_in), .mem_addr_in(ma),
    .mem_wdata_in(md), .mem_rd_grant_out(gnt), .op_start_out(start), .op_cmd_out(cmd),
    .op_word_addr_out(waddr), .op_data_out(wdata), .program_busy_flag_out(busy));
  task report_and_stop;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task rd_chk(input logic [7:0] a, e);
    i_nvm_prog_model.reg_op(1'b0, a, 8'h00);
    `CHK("rdata", e, rdata)
  endtask
  task grant_chk(input logic e); // level request, combinational grant
    @(posedge clk_in); #1;
    mem_rd_in = 1'b1;
    #2 `CHK("grant", e, gnt)
    @(posedge clk_in); #1;
    mem_rd_in = 1'b0;
  endtask
  task wait_idle(output int n); // bounded poll, a hang ends the run
    for (int i = 0; i < 40 && busy !== 1'b0; i++) begin
      @(posedge clk_in);
      #1;
    end
    n = cyc;
    if (busy !== 1'b0) begin
      error_cnt++;
      report_and_stop;
    end
  endtask
  task t_word;
    int t0, n;
    i_nvm_prog_model.reg_op(1'b1, 8'h33, 8'hDD);
    rd_chk(8'h33, 8'h1D);
    i_nvm_prog_model.mem_wr(10'h02A, 8'h5A);
    `CHK("early", 1'b0, start)
    i_nvm_prog_model.mem_wr(10'h02B, 8'hC3);
    `CHK("start", 1'b1, start)
    `CHK("data", 16'hC35A, wdata)
    `CHK("waddr", 9'h015, waddr)
    `CHK("busy", 1'b1, busy)
    t0 = cyc;
    grant_chk(1'b0);
    i_nvm_prog_model.reg_op(1'b1, 8'h33, 8'h10);
    rd_chk(8'h32, 8'h80);
    rd_chk(8'h33, 8'h1D);
    wait_idle(n);
    `CHK("busy_len", WRITE_LEN_TB + 1, n - t0)
    rd_chk(8'h32, 8'h00);
    grant_chk(1'b1);
    $display("word write done");
  endtask
  task t_ops;
    logic [5:0] c [3] = '{6'h10, 6'h14, 6'h00};
    int t0, n;
    foreach (c[k]) begin
      i_nvm_prog_model.reg_op(1'b1, 8'h33, {2'b00, c[k]});
      i_nvm_prog_model.mem_wr(10'h101, 8'hFF);
      t0 = cyc;
      `CHK("start", c[k] != 6'h00, start)
      if (c[k] != 6'h00) `CHK("cmd", c[k], cmd)
      wait_idle(n);
      `CHK("busy_len", (c[k] != 6'h00) ? ERASE_LEN_TB + 1 : 0, n - t0)
    end
    $display("command codes done");
  endtask
  task t_reset; // reset in the middle of an erase
    i_nvm_prog_model.reg_op(1'b1, 8'h33, 8'h14);
    i_nvm_prog_model.mem_wr(10'h001, 8'h00);
    `CHK("busy", 1'b1, busy)
    @(posedge clk_in); #1;
    resetn_in = 1'b0;
    #1 `CHK("rst_busy", 1'b0, busy)
    repeat (2) @(posedge clk_in);
    #1;
    resetn_in = 1'b1;
    rd_chk(8'h32, 8'h00);
    rd_chk(8'h33, 8'h00);
    $display("mid-run reset done");
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    #1 resetn_in = 1'b1;
    rd_chk(8'h32, 8'h00);
    rd_chk(8'h33, 8'h00);
    $display("reset values done");
    t_word;
    t_ops;
    t_reset;
    report_and_stop;
  end
endmodule // nvm_command_busy_control_tb
